// file: verilog/fws_host_ctrl.sv
`timescale 1ns/10ps
module fws_host_ctrl #(
    parameter int ADDR_W = fws_pkg::ADDR_W,
    parameter int DATA_W = fws_pkg::DATA_W,
    parameter int PROT_CYC = fws_pkg::PROT_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clkEn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // flash bus pins
    output logic [ADDR_W-1:0] flashAddr,
    output logic [DATA_W-1:0] flashDqOut,
    output logic flashDqOe,
    input wire logic [DATA_W-1:0] flashDqIn,
    output logic flashCeN,
    output logic flashWeN,
    output logic flashOeN,
    output logic flashResetN,
    input wire logic flashDoneLineN,
    // high voltage level switches
    output logic hvResetEn,
    output logic hvA9En,
    output logic hvOeEn
);
    import fws_pkg::*;

    typedef enum {
        S_IDLE, S_WR, S_RD, S_P1, S_P2, S_P3, S_P4, S_RST,
        S_E1, S_E2, S_E3, S_HV, S_PULSE, S_VFY, S_DONE
    } fws_state_t;

    function automatic logic opValid(input logic [OP_W-1:0] code);
        opValid = (code >= OP_WRITE) && (code <= OP_VERIFY);
    endfunction

    function automatic logic isCyc(input fws_state_t s);
        isCyc = (s != S_IDLE) && (s != S_HV) && (s != S_DONE);
    endfunction

    fws_cyc_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) cyc ();

    // bus side state
    logic aPend_r, aPend_nxt;
    logic aWr_r, aWr_nxt;
    logic [REG_AW-1:0] aIdx_r, aIdx_nxt;
    logic [OP_W-1:0] ctrlOp_r, ctrlOp_nxt;
    logic tempUnprot_r, tempUnprot_nxt;
    logic hwReset_r, hwReset_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    // sequencer state
    fws_state_t state_r, state_nxt;
    logic [OP_W-1:0] op_r, op_nxt;
    logic t1_r, t1_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic done_r, done_nxt;
    logic fail_r, fail_nxt;
    logic rej_r, rej_nxt;
    logic prot_r, prot_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic rdyS1_r, rdyS1_nxt;
    logic rdyS2_r, rdyS2_nxt;
    logic hvA9_r, hvA9_nxt;
    logic hvOe_r, hvOe_nxt;

    logic addrPhase;
    logic startOp;
    logic [OP_W-1:0] startCode;
    logic busy;
    logic [31:0] statusWord;

    assign busy = (state_r != S_IDLE);
    assign addrPhase = hsel && htrans[HTRANS_ACT_BIT] && hready;
    assign startCode = hwdata[CTRL_OP_LSB +: OP_W];
    // a start while busy is dropped, not queued
    assign startOp = aPend_r && aWr_r && (aIdx_r == REG_CTRL) && !busy && opValid(startCode);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign hvResetEn = tempUnprot_r;
    assign flashResetN = !hwReset_r;
    assign hvA9En = hvA9_r;
    assign hvOeEn = hvOe_r;
    assign cyc.req = isCyc(state_r);

    always_comb begin
        statusWord = '0;
        statusWord[ST_BUSY] = busy;
        statusWord[ST_DONE] = done_r;
        statusWord[ST_FAIL] = fail_r;
        statusWord[ST_REJ] = rej_r;
        statusWord[ST_READY] = rdyS2_r;
        statusWord[ST_PROT] = prot_r;
    end

    always_comb begin
        aPend_nxt = addrPhase;
        aWr_nxt = hwrite;
        aIdx_nxt = haddr[REG_AW-1:0];
        ctrlOp_nxt = ctrlOp_r;
        tempUnprot_nxt = tempUnprot_r;
        hwReset_nxt = hwReset_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        hrdata_nxt = hrdata_r;
        if (aPend_r && aWr_r) begin
            case (aIdx_r)
                REG_CTRL: begin
                    tempUnprot_nxt = hwdata[CTRL_TEMP_BIT];
                    hwReset_nxt = hwdata[CTRL_RST_BIT];
                    if (startOp) begin
                        ctrlOp_nxt = startCode;
                    end
                end
                REG_ADDR: begin
                    if (!busy) begin
                        addr_nxt = hwdata[ADDR_W-1:0];
                    end
                end
                REG_WDATA: begin
                    if (!busy) begin
                        wdata_nxt = hwdata[DATA_W-1:0];
                    end
                end
                default: ;
            endcase
        end
        if (addrPhase && !hwrite) begin
            case (haddr[REG_AW-1:0])
                REG_CTRL: begin
                    hrdata_nxt = '0;
                    hrdata_nxt[CTRL_OP_LSB +: OP_W] = ctrlOp_r;
                    hrdata_nxt[CTRL_TEMP_BIT] = tempUnprot_r;
                    hrdata_nxt[CTRL_RST_BIT] = hwReset_r;
                end
                REG_ADDR: hrdata_nxt = 32'(addr_r);
                REG_WDATA: hrdata_nxt = 32'(wdata_r);
                REG_STATUS: hrdata_nxt = statusWord;
                REG_RDATA: hrdata_nxt = 32'(rdata_r);
                default: hrdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            aPend_r <= 1'b0;
            aWr_r <= 1'b0;
            aIdx_r <= '0;
            ctrlOp_r <= OP_NONE;
            tempUnprot_r <= 1'b0;
            hwReset_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= '0;
            hrdata_r <= '0;
        end else if (clkEn) begin
            aPend_r <= aPend_nxt;
            aWr_r <= aWr_nxt;
            aIdx_r <= aIdx_nxt;
            ctrlOp_r <= ctrlOp_nxt;
            tempUnprot_r <= tempUnprot_nxt;
            hwReset_r <= hwReset_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    // attributes of the cycle the current state asks for
    always_comb begin
        cyc.wr = 1'b0;
        cyc.longPulse = 1'b0;
        cyc.addr = addr_r;
        cyc.wdata = wdata_r;
        case (state_r)
            S_WR: cyc.wr = 1'b1;
            S_RST: begin
                cyc.wr = 1'b1;
                cyc.wdata = CMD_RESET;
            end
            S_E2: begin
                cyc.wr = 1'b1;
                cyc.wdata = CMD_SECT_ERASE;
            end
            S_PULSE: begin
                cyc.wr = 1'b1;
                cyc.longPulse = 1'b1;
                if (op_r == OP_UNPROT) begin
                    cyc.addr[A_BIT6] = 1'b1;
                end
            end
            S_VFY: begin
                cyc.addr[A_BIT1] = 1'b1;
                cyc.addr[A_BIT0] = 1'b0;
                cyc.addr[A_BIT6] = 1'b0;
            end
            default: ;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        t1_nxt = t1_r;
        cnt_nxt = cnt_r;
        done_nxt = done_r;
        fail_nxt = fail_r;
        rej_nxt = rej_r;
        prot_nxt = prot_r;
        rdata_nxt = rdata_r;
        rdyS1_nxt = flashDoneLineN;
        rdyS2_nxt = rdyS1_r;
        if (cyc.ack) begin
            rdata_nxt = cyc.rdata;
        end
        case (state_r)
            S_IDLE: begin
                if (startOp) begin
                    op_nxt = startCode;
                    done_nxt = 1'b0;
                    fail_nxt = 1'b0;
                    rej_nxt = 1'b0;
                    prot_nxt = 1'b0;
                    cnt_nxt = CNT_W'(HV_SETTLE_CYC - 1);
                    case (startCode)
                        OP_WRITE: state_nxt = S_WR;
                        OP_READ: state_nxt = S_RD;
                        OP_POLL: state_nxt = S_P1;
                        OP_ERADD: state_nxt = S_E1;
                        OP_PROT, OP_UNPROT, OP_VERIFY: state_nxt = S_HV;
                        default: state_nxt = S_IDLE;
                    endcase
                end
            end
            S_WR, S_RD, S_RST, S_PULSE: begin
                if (cyc.ack) begin
                    state_nxt = S_DONE;
                end
            end
            S_P1, S_P3: begin
                if (cyc.ack) begin
                    t1_nxt = cyc.rdata[DQ_TOG1];
                    state_nxt = (state_r == S_P1) ? S_P2 : S_P4;
                end
            end
            S_P2: begin
                if (cyc.ack) begin
                    if (cyc.rdata[DQ_TOG1] == t1_r) begin
                        state_nxt = S_DONE;
                    end else if (cyc.rdata[DQ_TIMEOUT]) begin
                        state_nxt = S_P3;
                    end else begin
                        t1_nxt = cyc.rdata[DQ_TOG1];
                    end
                end
            end
            S_P4: begin
                // still toggling after the timeout flag: the operation failed
                if (cyc.ack) begin
                    if (cyc.rdata[DQ_TOG1] == t1_r) begin
                        state_nxt = S_DONE;
                    end else begin
                        fail_nxt = 1'b1;
                        state_nxt = S_RST;
                    end
                end
            end
            S_E1: begin
                if (cyc.ack) begin
                    if (cyc.rdata[DQ_WINDOW]) begin
                        rej_nxt = 1'b1;
                        state_nxt = S_DONE;
                    end else begin
                        state_nxt = S_E2;
                    end
                end
            end
            S_E2: begin
                if (cyc.ack) begin
                    state_nxt = S_E3;
                end
            end
            S_E3: begin
                if (cyc.ack) begin
                    rej_nxt = cyc.rdata[DQ_WINDOW];
                    state_nxt = S_DONE;
                end
            end
            S_HV: begin
                if (cnt_r == '0) begin
                    state_nxt = (op_r == OP_VERIFY) ? S_VFY : S_PULSE;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            S_VFY: begin
                if (cyc.ack) begin
                    prot_nxt = cyc.rdata[DQ_BIT0];
                    state_nxt = S_DONE;
                end
            end
            S_DONE: begin
                done_nxt = 1'b1;
                state_nxt = S_IDLE;
            end
            default: state_nxt = S_IDLE;
        endcase
        // high voltage only while the special cycle is set up and runs
        hvA9_nxt = (state_nxt == S_HV) || (state_nxt == S_PULSE) || (state_nxt == S_VFY);
        hvOe_nxt = ((state_nxt == S_HV) || (state_nxt == S_PULSE)) && (op_nxt != OP_VERIFY);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_r <= S_IDLE;
            op_r <= OP_NONE;
            t1_r <= 1'b0;
            cnt_r <= '0;
            done_r <= 1'b0;
            fail_r <= 1'b0;
            rej_r <= 1'b0;
            prot_r <= 1'b0;
            rdata_r <= '0;
            rdyS1_r <= 1'b1;
            rdyS2_r <= 1'b1;
            hvA9_r <= 1'b0;
            hvOe_r <= 1'b0;
        end else if (clkEn) begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            t1_r <= t1_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
            fail_r <= fail_nxt;
            rej_r <= rej_nxt;
            prot_r <= prot_nxt;
            rdata_r <= rdata_nxt;
            rdyS1_r <= rdyS1_nxt;
            rdyS2_r <= rdyS2_nxt;
            hvA9_r <= hvA9_nxt;
            hvOe_r <= hvOe_nxt;
        end
    end

    fws_pin_cycle #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W),
        .PROT_CYC(PROT_CYC)
    ) uCyc (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clkEn(clkEn),
        .cyc(cyc),
        .pinAddr(flashAddr),
        .pinDqOut(flashDqOut),
        .pinDqOe(flashDqOe),
        .pinDqIn(flashDqIn),
        .pinCeN(flashCeN),
        .pinWeN(flashWeN),
        .pinOeN(flashOeN)
    );
endmodule

// file: verilog/fws_pkg.sv
package fws_pkg;
    // system clock
    localparam int CLK_NS = 10;
    // flash bus shape
    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;
    // pin timing, in ns
    localparam int WP_NS = 45;
    localparam int RD_NS = 90;
    localparam int REC_NS = 45;
    localparam int PROT_PULSE_NS = 10000;
    localparam int HV_SETTLE_NS = 40;
    // derived cycle counts, least times rounded up
    localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_CYC = (RD_NS + CLK_NS - 1) / CLK_NS;
    localparam int REC_CYC = (REC_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROT_CYC = (PROT_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HV_SETTLE_CYC = (HV_SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_STAGES = 2;
    localparam int CNT_W = 16;
    // register map
    localparam int REG_AW = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam int HTRANS_ACT_BIT = 1;
    // control fields
    localparam int CTRL_OP_LSB = 0;
    localparam int OP_W = 4;
    localparam int CTRL_TEMP_BIT = 8;
    localparam int CTRL_RST_BIT = 9;
    localparam logic [3:0] OP_NONE = 4'h0;
    localparam logic [3:0] OP_WRITE = 4'h1;
    localparam logic [3:0] OP_READ = 4'h2;
    localparam logic [3:0] OP_POLL = 4'h3;
    localparam logic [3:0] OP_ERADD = 4'h4;
    localparam logic [3:0] OP_PROT = 4'h5;
    localparam logic [3:0] OP_UNPROT = 4'h6;
    localparam logic [3:0] OP_VERIFY = 4'h7;
    // status fields
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_REJ = 3;
    localparam int ST_READY = 4;
    localparam int ST_PROT = 5;
    // flash status byte positions
    localparam int DQ_POLL = 7;
    localparam int DQ_TOG1 = 6;
    localparam int DQ_TIMEOUT = 5;
    localparam int DQ_WINDOW = 3;
    localparam int DQ_TOG2 = 2;
    localparam int DQ_BIT0 = 0;
    // address pins used by protect modes
    localparam int A_BIT9 = 9;
    localparam int A_BIT6 = 6;
    localparam int A_BIT1 = 1;
    localparam int A_BIT0 = 0;
    // flash commands
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam logic [7:0] CMD_SECT_ERASE = 8'h30;
endpackage

// file: verilog/fws_cyc_if.sv
`timescale 1ns/10ps
interface fws_cyc_if #(
    parameter int ADDR_W = fws_pkg::ADDR_W,
    parameter int DATA_W = fws_pkg::DATA_W
);
    logic req;
    logic wr;
    logic longPulse;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic ack;
    logic [DATA_W-1:0] rdata;
    modport host (output req, wr, longPulse, addr, wdata, input ack, rdata);
    modport eng (input req, wr, longPulse, addr, wdata, output ack, rdata);
endinterface

// file: verilog/fws_pin_cycle.sv
`timescale 1ns/10ps
module fws_pin_cycle #(
    parameter int ADDR_W = fws_pkg::ADDR_W,
    parameter int DATA_W = fws_pkg::DATA_W,
    parameter int PROT_CYC = fws_pkg::PROT_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clkEn,
    // cycle requests
    fws_cyc_if.eng cyc,
    // flash pins
    output logic [ADDR_W-1:0] pinAddr,
    output logic [DATA_W-1:0] pinDqOut,
    output logic pinDqOe,
    input wire logic [DATA_W-1:0] pinDqIn,
    output logic pinCeN,
    output logic pinWeN,
    output logic pinOeN
);
    import fws_pkg::*;

    typedef enum {C_IDLE, C_SETUP, C_ACT, C_REC} fws_cyc_state_t;

    fws_cyc_state_t st_r, st_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic wr_r, wr_nxt;
    logic long_r, long_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic [DATA_W-1:0] dqS1_r, dqS1_nxt;
    logic [DATA_W-1:0] dqS2_r, dqS2_nxt;
    logic ceN_r, ceN_nxt;
    logic weN_r, weN_nxt;
    logic oeN_r, oeN_nxt;
    logic dqOe_r, dqOe_nxt;

    assign cyc.ack = (st_r == C_REC) && (cnt_r == '0);
    assign cyc.rdata = rdata_r;
    assign pinAddr = addr_r;
    assign pinDqOut = wdata_r;
    assign pinDqOe = dqOe_r;
    assign pinCeN = ceN_r;
    assign pinWeN = weN_r;
    assign pinOeN = oeN_r;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        wr_nxt = wr_r;
        long_nxt = long_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        ceN_nxt = ceN_r;
        weN_nxt = weN_r;
        oeN_nxt = oeN_r;
        dqOe_nxt = dqOe_r;
        dqS1_nxt = pinDqIn;
        dqS2_nxt = dqS1_r;
        case (st_r)
            C_IDLE: begin
                if (cyc.req) begin
                    wr_nxt = cyc.wr;
                    long_nxt = cyc.longPulse;
                    addr_nxt = cyc.addr;
                    wdata_nxt = cyc.wdata;
                    dqOe_nxt = cyc.wr;
                    st_nxt = C_SETUP;
                end
            end
            C_SETUP: begin
                // oe stays high through a write and we through a read
                ceN_nxt = 1'b0;
                weN_nxt = !wr_r;
                oeN_nxt = wr_r;
                // whole-cycle strobes, far wider than any glitch filter
                if (!wr_r) begin
                    cnt_nxt = CNT_W'(RD_CYC + SYNC_STAGES - 1);
                end else if (long_r) begin
                    cnt_nxt = CNT_W'(PROT_CYC - 1);
                end else begin
                    cnt_nxt = CNT_W'(WP_CYC - 1);
                end
                st_nxt = C_ACT;
            end
            C_ACT: begin
                if (cnt_r == '0) begin
                    ceN_nxt = 1'b1;
                    weN_nxt = 1'b1;
                    oeN_nxt = 1'b1;
                    if (!wr_r) begin
                        rdata_nxt = dqS2_r;
                    end
                    cnt_nxt = CNT_W'(REC_CYC - 1);
                    st_nxt = C_REC;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            C_REC: begin
                // data held past the strobe edge, released before the next cycle
                if (cnt_r == '0) begin
                    dqOe_nxt = 1'b0;
                    st_nxt = C_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default: st_nxt = C_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_r <= C_IDLE;
            cnt_r <= '0;
            wr_r <= 1'b0;
            long_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= '0;
            rdata_r <= '0;
            dqS1_r <= '0;
            dqS2_r <= '0;
            ceN_r <= 1'b1;
            weN_r <= 1'b1;
            oeN_r <= 1'b1;
            dqOe_r <= 1'b0;
        end else if (clkEn) begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            wr_r <= wr_nxt;
            long_r <= long_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            dqS1_r <= dqS1_nxt;
            dqS2_r <= dqS2_nxt;
            ceN_r <= ceN_nxt;
            weN_r <= weN_nxt;
            oeN_r <= oeN_nxt;
            dqOe_r <= dqOe_nxt;
        end
    end
endmodule

// file: verification/fws_flash_model.sv
`timescale 1ns/10ps
module fws_flash_model (
    // flash pins
    input wire logic [19:0] addr,
    input wire logic [7:0] dq,
    input wire logic ceN,
    input wire logic weN,
    input wire logic oeN,
    input wire logic hvRst,
    input wire logic hvA9,
    input wire logic hvOe,
    // forces a pulse-count overrun
    input wire logic stuck,
    output logic [7:0] dqIn,
    output logic doneN
);
    logic [7:0] mem = 8'h00;
    logic [7:0] val;
    logic prot = 1'b0;
    logic tog = 1'b0;
    bit wrAct;
    int busy = 0;
    assign doneN = (busy == 0);
    // released pins read back inverted so a stale value never passes
    assign dqIn = oeN ? ~val : val;
    // bit type keeps the time-zero unknowns from looking like an edge
    always_comb wrAct = !ceN && !weN && oeN && !hvOe;
    always_comb begin
        if (hvA9) begin
            val = {7'h00, prot};
        end else if (busy > 0) begin
            val = {~mem[7], tog, stuck, 5'h00};
        end else begin
            val = mem;
        end
    end
    always @(negedge oeN) begin
        tog <= ~tog;
        if (busy > 0 && !stuck) begin
            busy <= busy - 1;
        end
    end
    always @(posedge weN) begin
        if (hvA9 && hvOe) begin
            prot <= ~addr[6];
        end
    end
    always @(posedge wrAct) begin
        if (dq == 8'hf0) begin
            busy <= 0;
        end else if (!prot || hvRst) begin
            mem <= dq;
            busy <= 3;
        end
    end
endmodule

// file: verification/fws_host_ctrl_chk.sv
`timescale 1ns/10ps
module fws_host_ctrl_chk #(
    parameter int PROT_CYC = 8
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [fws_pkg::ADDR_W-1:0] flashAddr,
    input wire logic flashDqOe,
    input wire logic flashCeN,
    input wire logic flashWeN,
    input wire logic flashOeN,
    input wire logic hvA9En,
    input wire logic hvOeEn
);
    logic [15:0] lowCnt_r;
    logic [15:0] lowCnt_nxt;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    always_comb lowCnt_nxt = flashWeN ? 16'h0 : lowCnt_r + 16'h1;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lowCnt_r <= 16'h0;
        end else begin
            lowCnt_r <= lowCnt_nxt;
        end
    end
    a_write_levels: assert property (!flashWeN && !hvOeEn |-> flashOeN && !flashCeN && flashDqOe)
        else $error("write strobe without write levels");
    a_wr_pulse_width: assert property ($fell(flashWeN) && !hvOeEn |-> !flashWeN [*5] ##1 flashWeN)
        else $error("write pulse width wrong");
    a_read_no_drive: assert property (!flashOeN && !hvOeEn |-> flashWeN && !flashDqOe)
        else $error("read while driving or writing");
    a_prot_hv_pair: assert property (!flashWeN && hvOeEn |-> hvA9En)
        else $error("protect pulse without a9 level");
    a_prot_hv_hold: assert property ($rose(flashWeN) && $past(hvOeEn) |-> hvOeEn && hvA9En)
        else $error("high voltage dropped before pulse end");
    a_prot_pulse_len: assert property ($rose(flashWeN) && hvOeEn |-> lowCnt_r == 16'(PROT_CYC))
        else $error("protect pulse length wrong");
    a_addr_held: assert property (!flashCeN && !$past(flashCeN) |-> $stable(flashAddr))
        else $error("address moved inside a cycle");
    a_verify_addr: assert property (hvA9En && !hvOeEn && !flashOeN |-> flashAddr[1] && !flashAddr[0] && !flashAddr[6])
        else $error("verify read address wrong");
    cover property ($rose(flashWeN) && hvOeEn);
    cover property (hvA9En && !flashOeN);
    cover property ($fell(flashWeN) && !hvOeEn);
endmodule
bind fws_host_ctrl fws_host_ctrl_chk #(.PROT_CYC(PROT_CYC)) fws_host_ctrl_chk_inst (
    .clk_sys(clk_sys), .nrst(nrst), .flashAddr(flashAddr), .flashDqOe(flashDqOe),
    .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
    .hvA9En(hvA9En), .hvOeEn(hvOeEn));

// file: verification/fws_host_ctrl_tb.sv
`timescale 1ns/10ps
module fws_host_ctrl_tb;
    import fws_pkg::*;
    typedef struct packed {
        logic [3:0] op;
        logic [7:0] wd;
        logic [7:0] st;
        logic [7:0] rd;
    } fws_row_t;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic stuck = 1'b0;
    logic hreadyout, hresp, flashDqOe, flashCeN, flashWeN, flashOeN, flashResetN;
    logic doneN, hvResetEn, hvA9En, hvOeEn;
    logic [31:0] hrdata, st;
    logic [19:0] flashAddr;
    logic [7:0] flashDqOut, flashDqIn;
    int n_errors = 0;
    int checks = 0;
    fws_row_t rows[12] = '{
        '{4'h1, 8'h5a, 8'h02, 8'h00},
        '{4'h3, 8'h00, 8'h02, 8'h00},
        '{4'h2, 8'h00, 8'h02, 8'h5a},
        '{4'h5, 8'h00, 8'h02, 8'h00},
        '{4'h7, 8'h00, 8'h22, 8'h00},
        '{4'h1, 8'h33, 8'h02, 8'h00},
        '{4'h2, 8'h00, 8'h02, 8'h5a},
        '{4'h6, 8'h00, 8'h02, 8'h00},
        '{4'h7, 8'h00, 8'h02, 8'h00},
        '{4'h1, 8'h08, 8'h02, 8'h00},
        '{4'h3, 8'h00, 8'h02, 8'h00},
        '{4'h4, 8'h00, 8'h0a, 8'h00}};
    fws_host_ctrl #(.PROT_CYC(8)) fws_host_ctrl_inst (
        .clk_sys(clk_sys), .nrst(nrst), .clkEn(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
        .flashDqIn(flashDqIn), .flashCeN(flashCeN), .flashWeN(flashWeN),
        .flashOeN(flashOeN), .flashResetN(flashResetN), .flashDoneLineN(doneN),
        .hvResetEn(hvResetEn), .hvA9En(hvA9En), .hvOeEn(hvOeEn));
    fws_flash_model fws_flash_model_inst (
        .addr(flashAddr), .dq(flashDqOut), .ceN(flashCeN), .weN(flashWeN),
        .oeN(flashOeN), .hvRst(hvResetEn), .hvA9(hvA9En), .hvOe(hvOeEn),
        .stuck(stuck), .dqIn(flashDqIn), .doneN(doneN));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic test_done;
        if (n_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        r = hrdata;
    endtask
    // waits on the busy flag; the poll op has no bound of its own
    task automatic run(input logic [11:0] op, input logic [7:0] wd, output logic [31:0] s);
        xfer(1'b1, REG_WDATA, {24'h0, wd}, s);
        xfer(1'b1, REG_CTRL, {20'h0, op}, s);
        for (int i = 0; i < 4000; i++) begin
            xfer(1'b0, REG_STATUS, 32'h0, s);
            if (s[ST_BUSY] === 1'b0) break;
        end
    endtask
    initial begin
        #400000;
        n_errors++;
        test_done;
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        xfer(1'b0, REG_STATUS, 32'h0, st);
        chk("status", 32'h10, st);
        xfer(1'b0, 8'h20, 32'h0, st);
        chk("unmapped", 32'h0, st);
        xfer(1'b1, REG_ADDR, 32'h10, st);
        foreach (rows[i]) begin
            run(rows[i].op, rows[i].wd, st);
            chk("status", {24'h0, rows[i].st}, st & 32'h2f);
            if (rows[i].op == OP_READ) begin
                xfer(1'b0, REG_RDATA, 32'h0, st);
                chk("rdata", {24'h0, rows[i].rd}, st);
            end
        end
        stuck <= 1'b1;
        run(OP_WRITE, 8'h11, st);
        run(OP_POLL, 8'h00, st);
        chk("timeout", 32'h6, st & 32'h2f);
        stuck <= 1'b0;
        // byte left after the reset command has bit 3 clear: window open
        run(OP_ERADD, 8'h00, st);
        chk("erase_add", 32'h2, st & 32'h2f);
        run(OP_POLL, 8'h00, st);
        xfer(1'b1, REG_CTRL, 32'h200, st);
        xfer(1'b0, REG_CTRL, 32'h0, st);
        chk("ctrl", 32'h203, st);
        chk("reset_pin", 32'h0, flashResetN);
        chk("hresp", 32'h0, hresp);
        run(OP_PROT, 8'h00, st);
        run(12'h101, 8'h77, st);
        chk("hv_reset", 32'h1, hvResetEn);
        run(OP_POLL, 8'h00, st);
        run(OP_READ, 8'h00, st);
        xfer(1'b0, REG_RDATA, 32'h0, st);
        chk("temp_write", 32'h77, st);
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        xfer(1'b0, REG_CTRL, 32'h0, st);
        chk("ctrl_reset", 32'h0, st);
        test_done;
    end
endmodule
